// *** isc_master_model.sv ***
// behavioural i2c bus master that drives the clock line
`timescale 1ns/1ps
`default_nettype none

module isc_master_model
(
    input wire logic run_in,
    input wire logic park_low_in,
    input wire logic slave_oe_in,
    output logic scl_out,
    output var int falls_out
);
    logic drive_low;

    // open drain wire with pull-up, low while any party pulls it
    assign scl_out = !(drive_low || park_low_in || slave_oe_in);

    // clock stands still high between frames, 800 ns period inside
    initial
    begin
        drive_low = 1'b0;
        falls_out = 0;
        forever
        begin
            wait (run_in);
            drive_low = 1'b1;
            falls_out++;
            #400 drive_low = 1'b0;
            // clock sync: a stretching slave stalls the high phase
            #200 wait (scl_out);
            #200;
        end
    end
endmodule

`default_nettype wire

// *** isc_pkg.sv ***
// shared constants and types for the i2c slave control block
package isc_pkg;

    // register byte offsets on the apb bus
    localparam logic [11:0] ISC_OFF_CTRL = 12'h000;
    localparam logic [11:0] ISC_OFF_STS = 12'h004;
    localparam logic [11:0] ISC_OFF_MASK = 12'h008;

    // decoded register index, unmapped last
    localparam logic [1:0] ISC_IDX_CTRL = 2'h0;
    localparam logic [1:0] ISC_IDX_STS = 2'h1;
    localparam logic [1:0] ISC_IDX_MASK = 2'h2;
    localparam logic [1:0] ISC_IDX_NONE = 2'h3;

    // slave control layout, 16 bits, reserved and foreign bits read zero
    typedef struct packed {
        logic [4:0] rsvd;
        logic slave_tx_irq_enable;
        logic slave_rx_irq_enable;
        logic stop_detect_irq_enable;
        logic force_nack_next_byte;
        logic clock_stretch_enable;
        logic [5:0] other;
    } isc_ctrl_t;

    // writable bits of slave control, 10 down to 6
    localparam logic [15:0] ISC_CTRL_WMASK = 16'h07c0;
    localparam logic [15:0] ISC_CTRL_RST = 16'h0000;

    // event layout shared by status and mask registers
    typedef struct packed {
        logic tx;
        logic stop;
        logic rx;
    } isc_evt_t;

    localparam logic [2:0] ISC_STS_RST = 3'h0;
    localparam logic [2:0] ISC_MASK_RST = 3'h0;

    // idle level of the bus clock line
    localparam logic ISC_SCL_IDLE = 1'b1;

    // clock stretch sequencer
    typedef enum {
        ISC_ST_IDLE,
        ISC_ST_WAIT_FALL,
        ISC_ST_HOLD
    } isc_stretch_t;

endpackage

// *** isc_scl_sync.sv ***
// two-flop synchroniser and falling edge finder for the bus clock pin
`timescale 1ns/1ps
`default_nettype none

module isc_scl_sync
    import isc_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic scl_in,
    output logic scl_sync_out,
    output logic scl_fall_out
);

    logic meta_ff, nxt_meta;
    logic sync_ff, nxt_sync;
    logic prev_ff, nxt_prev;
    logic fall_ff, nxt_fall;

    // only the second stage looks at the first one
    always_comb
    begin
        nxt_meta = scl_in;
        nxt_sync = meta_ff;
        nxt_prev = sync_ff;
        nxt_fall = prev_ff & ~sync_ff;
    end

    // idle high so reset fakes no falling edge while the bus line is high at reset release
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            meta_ff <= ISC_SCL_IDLE;
            sync_ff <= ISC_SCL_IDLE;
            prev_ff <= ISC_SCL_IDLE;
            fall_ff <= 1'b0;
        end
        else
        begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
            prev_ff <= nxt_prev;
            fall_ff <= nxt_fall;
        end
    end

    assign scl_sync_out = prev_ff;
    assign scl_fall_out = fall_ff;

endmodule

`default_nettype wire

// *** isc_slave_ctrl.sv ***
// i2c slave control: irq enables, forced nack and scl stretch, apb regs
//
// Function
// - receive enable set: each received byte raises an interrupt
// - stop enable set: a detected stop condition raises an interrupt
// - forced nack set: next byte is answered with not-acknowledge
// - forced nack clear: hardware picks ack or nack per byte
// - stretch set while clock low: hold clock low, stalling master
// - transmit enable set: each transmitted byte raises an interrupt
// - stretch set while clock high: hold low after next falling edge
// - stretch cleared: stop holding, release clock to the bus
`timescale 1ns/1ps
`default_nettype none

module isc_slave_ctrl
    import isc_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic rx_byte_in,
    input wire logic tx_byte_in,
    input wire logic stop_det_in,
    input wire logic hw_nack_in,
    output logic nack_out,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe_out,
    output logic irq_out
);

    // map a byte address to a register index
    function automatic logic [1:0] isc_decode(input logic [11:0] addr);
        logic [1:0] idx;
        idx = ISC_IDX_NONE;
        case (addr)
            ISC_OFF_CTRL: idx = ISC_IDX_CTRL;
            ISC_OFF_STS: idx = ISC_IDX_STS;
            ISC_OFF_MASK: idx = ISC_IDX_MASK;
            default: idx = ISC_IDX_NONE;
        endcase
        return idx;
    endfunction

    isc_ctrl_t ctrl_ff, nxt_ctrl;
    isc_evt_t sts_ff, nxt_sts;
    isc_evt_t mask_ff, nxt_mask;
    isc_evt_t evt;
    isc_evt_t w1c;
    isc_stretch_t st_ff, nxt_st;
    logic [31:0] prdata_ff, nxt_prdata;
    logic pready_ff, nxt_pready;
    logic pslverr_ff, nxt_pslverr;
    logic irq_ff, nxt_irq;
    logic nack_ff, nxt_nack;
    logic scl_oe_ff, nxt_scl_oe;
    logic scl_sync;
    logic scl_fall;
    logic [1:0] idx;
    logic acc_first;
    logic commit;
    logic wr_commit;

    // pin crossing: the bus clock is foreign to ref_clk_in
    isc_scl_sync i_isc_scl_sync (
        .ref_clk_in(ref_clk_in),
        .arst_n_in(arst_n_in),
        .scl_in(scl_in),
        .scl_sync_out(scl_sync),
        .scl_fall_out(scl_fall)
    );

    // apb phase decode; one wait state so every answer is a flop
    assign idx = isc_decode(paddr_in);
    assign acc_first = psel_in & penable_in & ~pready_ff;
    assign commit = psel_in & penable_in & pready_ff;
    assign wr_commit = commit & pwrite_in & ~pslverr_ff;

    // apb answer: ready and read data prepared in the first access cycle
    always_comb
    begin
        nxt_pready = acc_first;
        nxt_pslverr = acc_first & (idx == ISC_IDX_NONE);
        nxt_prdata = 32'h0000_0000;
        if (acc_first && !pwrite_in)
        begin
            case (idx)
                ISC_IDX_CTRL: nxt_prdata = {16'h0000, ctrl_ff};
                ISC_IDX_STS: nxt_prdata = {29'h0000_0000, sts_ff};
                ISC_IDX_MASK: nxt_prdata = {29'h0000_0000, mask_ff};
                default: nxt_prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end
        else
        begin
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff <= nxt_prdata;
        end
    end

    // control and mask writes; only the documented bits are kept
    always_comb
    begin
        nxt_ctrl = ctrl_ff;
        nxt_mask = mask_ff;
        w1c = ISC_STS_RST;
        if (wr_commit && idx == ISC_IDX_CTRL)
        begin
            nxt_ctrl = isc_ctrl_t'(pwdata_in[15:0] & ISC_CTRL_WMASK);
        end
        if (wr_commit && idx == ISC_IDX_MASK)
        begin
            nxt_mask = isc_evt_t'(pwdata_in[2:0]);
        end
        if (wr_commit && idx == ISC_IDX_STS)
        begin
            w1c = isc_evt_t'(pwdata_in[2:0]);
        end
    end

    // event sources are gated by their enables before they latch
    always_comb
    begin
        evt.rx = rx_byte_in & ctrl_ff.slave_rx_irq_enable;
        evt.stop = stop_det_in & ctrl_ff.stop_detect_irq_enable;
        evt.tx = tx_byte_in & ctrl_ff.slave_tx_irq_enable;
        // set beats a same-cycle write-one clear
        nxt_sts = (sts_ff & ~w1c) | evt;
        // irq follows the next status so it never lags the flags
        nxt_irq = |(nxt_sts & nxt_mask);
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            ctrl_ff <= isc_ctrl_t'(ISC_CTRL_RST);
            mask_ff <= isc_evt_t'(ISC_MASK_RST);
            sts_ff <= isc_evt_t'(ISC_STS_RST);
            irq_ff <= 1'b0;
        end
        else
        begin
            ctrl_ff <= nxt_ctrl;
            mask_ff <= nxt_mask;
            sts_ff <= nxt_sts;
            irq_ff <= nxt_irq;
        end
    end

    // acknowledge answer to the byte engine
    always_comb
    begin
        nxt_nack = ctrl_ff.force_nack_next_byte | hw_nack_in;
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            nack_ff <= 1'b0;
        end
        else
        begin
            nack_ff <= nxt_nack;
        end
    end

    // stretch sequencer; idle with enable set only right after setting
    always_comb
    begin
        nxt_st = st_ff;
        case (st_ff)
            ISC_ST_IDLE:
            begin
                // low at setting: hold at once
                if (ctrl_ff.clock_stretch_enable && !scl_sync)
                begin
                    nxt_st = ISC_ST_HOLD;
                end
                else if (ctrl_ff.clock_stretch_enable)
                begin
                    nxt_st = ISC_ST_WAIT_FALL;
                end
            end
            ISC_ST_WAIT_FALL:
            begin
                if (!ctrl_ff.clock_stretch_enable)
                begin
                    nxt_st = ISC_ST_IDLE;
                end
                // high at setting: hold after fall
                else if (scl_fall)
                begin
                    nxt_st = ISC_ST_HOLD;
                end
            end
            ISC_ST_HOLD:
            begin
                if (!ctrl_ff.clock_stretch_enable)
                begin
                    nxt_st = ISC_ST_IDLE;
                end
            end
            default: nxt_st = ISC_ST_IDLE;
        endcase
        nxt_scl_oe = (nxt_st == ISC_ST_HOLD);
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            st_ff <= ISC_ST_IDLE;
            scl_oe_ff <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
            scl_oe_ff <= nxt_scl_oe;
        end
    end

    // output drive; open drain so the driven level is always low
    assign prdata_out = prdata_ff;
    assign pready_out = pready_ff;
    assign pslverr_out = pslverr_ff;
    assign nack_out = nack_ff;
    assign irq_out = irq_ff;
    assign scl_oe_out = scl_oe_ff;
    assign scl_out = 1'b0;

    // checks on enable gating of the interrupt sources
    AST_RX_SETS: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (rx_byte_in && ctrl_ff.slave_rx_irq_enable) |=> sts_ff.rx)
    else $error("received byte with enable did not set status");

    AST_RX_GATED: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        $rose(sts_ff.rx) |->
            $past(rx_byte_in && ctrl_ff.slave_rx_irq_enable))
    else $error("receive status set without enabled event");

    AST_STOP_IRQ: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (stop_det_in && ctrl_ff.stop_detect_irq_enable && mask_ff.stop
            && !(commit && pwrite_in)) |=> (sts_ff.stop && irq_out))
    else $error("enabled unmasked stop did not interrupt");

    AST_STOP_GATED: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        $rose(sts_ff.stop) |->
            $past(stop_det_in && ctrl_ff.stop_detect_irq_enable))
    else $error("stop status set without enabled event");

    AST_TX_SETS: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (tx_byte_in && ctrl_ff.slave_tx_irq_enable) |=> sts_ff.tx)
    else $error("transmitted byte with enable did not set status");

    // checks on the acknowledge answer
    AST_FORCE_NACK: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        ctrl_ff.force_nack_next_byte |=> nack_out)
    else $error("forced nack not driven");

    AST_HW_ACK: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        !ctrl_ff.force_nack_next_byte |=> (nack_out == $past(hw_nack_in)))
    else $error("hardware ack decision not passed through");

    // checks on the stretch sequencer and the clock line drive
    AST_HOLD_LOW: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (st_ff == ISC_ST_IDLE && ctrl_ff.clock_stretch_enable && !scl_sync)
            |=> (scl_oe_out && st_ff == ISC_ST_HOLD))
    else $error("low clock not held after stretch set");

    AST_WAIT_FALL: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (st_ff == ISC_ST_WAIT_FALL && ctrl_ff.clock_stretch_enable
            && !scl_fall) |=> !scl_oe_out)
    else $error("clock held before its falling edge");

    AST_FALL_HOLD: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (st_ff == ISC_ST_WAIT_FALL && ctrl_ff.clock_stretch_enable
            && scl_fall) |=> scl_oe_out [*1] ##0 (st_ff == ISC_ST_HOLD))
    else $error("clock not held after falling edge");

    AST_RELEASE: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        $fell(ctrl_ff.clock_stretch_enable) |=> !scl_oe_out [*2])
    else $error("clock line not released after stretch cleared");

endmodule

`default_nettype wire

// *** tb_isc_slave_ctrl.sv ***
// self-checking bench for the i2c slave control block
`timescale 1ns/1ps
`default_nettype none

module tb_isc_slave_ctrl;
    import isc_pkg::*;

    logic clk, arst_n, psel, penable, pwrite, hw_nack, run, park;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, nack, scl_oe, irq, scl_wire, scl_lvl;
    logic [2:0] ev;
    int falls;
    int bad_count = 0;
    int comparisons = 0;

    isc_slave_ctrl i_isc_slave_ctrl (
        .ref_clk_in(clk), .arst_n_in(arst_n), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .rx_byte_in(ev[0]), .tx_byte_in(ev[2]),
        .stop_det_in(ev[1]), .hw_nack_in(hw_nack), .nack_out(nack),
        .scl_in(scl_wire), .scl_out(scl_lvl), .scl_oe_out(scl_oe),
        .irq_out(irq)
    );

    isc_master_model i_isc_master_model (
        .run_in(run), .park_low_in(park), .slave_oe_in(scl_oe),
        .scl_out(scl_wire), .falls_out(falls)
    );

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    // no cycle limit here: only the watchdog may end a stuck wait
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic err);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    // one-cycle event pulse, then two more edges for status to land
    task automatic pulse(input int i);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev[i] <= 1'b0;
        @(posedge clk);
        @(posedge clk);
    endtask

    task automatic t_regs;
        logic [31:0] q;
        logic e;
        apb(1'b0, ISC_OFF_CTRL, 32'h0, q, e);
        check("ctrl reset", q, 32'(ISC_CTRL_RST));
        apb(1'b0, ISC_OFF_STS, 32'h0, q, e);
        check("sts reset", q, 32'h0);
        apb(1'b0, ISC_OFF_MASK, 32'h0, q, e);
        check("mask reset", q, 32'(ISC_MASK_RST));
        apb(1'b0, 12'h00c, 32'h0, q, e);
        check("unmapped err", 32'(e), 32'h1);
        apb(1'b1, 12'h00c, 32'hffffffff, q, e);
        check("unmapped wr err", 32'(e), 32'h1);
        apb(1'b0, ISC_OFF_CTRL, 32'h0, q, e);
        check("unmapped wr ignored", q, 32'(ISC_CTRL_RST));
        apb(1'b1, ISC_OFF_CTRL, 32'hffffffff, q, e);
        apb(1'b0, ISC_OFF_CTRL, 32'h0, q, e);
        check("ctrl mask", q, 32'(ISC_CTRL_WMASK));
        apb(1'b1, ISC_OFF_CTRL, 32'h0, q, e);
        $display("test regs done");
    endtask

    task automatic t_events;
        logic [31:0] q;
        logic e;
        int cb[3] = '{9, 8, 10};
        apb(1'b1, ISC_OFF_MASK, 32'h7, q, e);
        for (int i = 0; i < 3; i++)
        begin
            // disabled source must leave status and irq alone
            apb(1'b1, ISC_OFF_CTRL, 32'h0, q, e);
            pulse(i);
            check("irq off", 32'(irq), 32'h0);
            apb(1'b1, ISC_OFF_CTRL, 32'h1 << cb[i], q, e);
            pulse(i);
            check("irq on", 32'(irq), 32'h1);
            apb(1'b0, ISC_OFF_STS, 32'h0, q, e);
            check("sts bit", q, 32'h1 << i);
            apb(1'b1, ISC_OFF_MASK, 32'h0, q, e);
            check("irq masked", 32'(irq), 32'h0);
            apb(1'b1, ISC_OFF_MASK, 32'h7, q, e);
            apb(1'b1, ISC_OFF_STS, 32'h1 << i, q, e);
            check("irq cleared", 32'(irq), 32'h0);
        end
        $display("test events done");
    endtask

    task automatic t_nack;
        logic [31:0] q;
        logic e;
        for (int k = 0; k < 4; k++)
        begin
            apb(1'b1, ISC_OFF_CTRL, 32'(k[1]) << 7, q, e);
            hw_nack <= k[0];
            repeat (3) @(posedge clk);
            check("nack", 32'(nack), 32'(k[1] | k[0]));
        end
        hw_nack <= 1'b0;
        $display("test nack done");
    endtask

    task automatic t_stretch;
        logic [31:0] q;
        logic e;
        // line high: no hold until the master pulls it down
        apb(1'b1, ISC_OFF_CTRL, 32'h40, q, e);
        repeat (8) @(posedge clk);
        check("oe idle", 32'(scl_oe), 32'h0);
        run <= 1'b1;
        repeat (20) @(posedge clk);
        run <= 1'b0;
        check("held", 32'(scl_wire), 32'h0);
        check("stalled", 32'(falls), 32'h1);
        apb(1'b1, ISC_OFF_CTRL, 32'h0, q, e);
        repeat (3) @(posedge clk);
        check("released", 32'(scl_wire), 32'h1);
        repeat (10) @(posedge clk);
        // line already low when enabled: hold at once
        park <= 1'b1;
        repeat (4) @(posedge clk);
        apb(1'b1, ISC_OFF_CTRL, 32'h40, q, e);
        repeat (3) @(posedge clk);
        park <= 1'b0;
        repeat (4) @(posedge clk);
        check("oe low set", 32'(scl_oe), 32'h1);
        check("drive level", 32'(scl_lvl), 32'h0);
        check("kept low", 32'(scl_wire), 32'h0);
        apb(1'b1, ISC_OFF_CTRL, 32'h0, q, e);
        repeat (3) @(posedge clk);
        check("oe cleared", 32'(scl_oe), 32'h0);
        $display("test stretch done");
    endtask

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // watchdog well beyond the few hundred cycles the tests take
    initial
    begin
        #2000000;
        bad_count++;
        report_and_stop();
    end

    initial
    begin
        arst_n = 1'b0;
        {psel, penable, pwrite, hw_nack, run, park} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        ev = 3'h0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_events();
        t_nack();
        t_stretch();
        report_and_stop();
    end
endmodule

`default_nettype wire
